// ---- logic_arith_pkg.sv ----
package logic_arith_pkg;
  // register byte offsets
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] INSTR_OFF = 12'h004;
  localparam logic [11:0] ACC_OFF = 12'h008;
  localparam logic [11:0] STATUS_OFF = 12'h00C;
  localparam logic [11:0] WDT_OFF = 12'h010;
  localparam logic [11:0] CYCLE_OFF = 12'h014;
  localparam logic [11:0] FILE_BASE = 12'h080;
  // control bit positions
  localparam int CTRL_QUARTER_BIT = 0;
  localparam int CTRL_CARRY_FUSE_BIT = 1;
  localparam int CTRL_PRESC_WDT_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h2;
  // status bit positions
  localparam int ST_OUTFLOW_BIT = 0;
  localparam int ST_NIBBLE_BIT = 1;
  localparam int ST_NULL_BIT = 2;
  localparam int ST_SLEEP_BIT = 3;
  localparam int ST_EXPIRY_BIT = 4;
  localparam logic [7:0] STATUS_RESET = 8'h18;
  // instruction clock divisors
  localparam logic [1:0] DIV_TURBO_LAST = 2'h0;
  localparam logic [1:0] DIV_QUARTER_LAST = 2'h3;
  // upper seven opcode bits
  localparam logic [6:0] OP_AND_FW = 7'h0B;
  localparam logic [6:0] OP_AND_WF = 7'h0A;
  localparam logic [6:0] OP_NOT = 7'h13;
  localparam logic [6:0] OP_OR_FW = 7'h09;
  localparam logic [6:0] OP_OR_WF = 7'h08;
  localparam logic [6:0] OP_XOR_FW = 7'h0D;
  localparam logic [6:0] OP_XOR_WF = 7'h0C;
  localparam logic [6:0] OP_ADD_FW = 7'h0F;
  localparam logic [6:0] OP_ADD_WF = 7'h0E;
  localparam logic [6:0] OP_CLR_F = 7'h03;
  localparam logic [6:0] OP_DEC = 7'h07;
  localparam logic [6:0] OP_DECSKIP = 7'h17;
  localparam logic [6:0] OP_INC = 7'h15;
  localparam logic [6:0] OP_INCSKIP = 7'h1F;
  localparam logic [6:0] OP_ROT_LEFT = 7'h1B;
  localparam logic [6:0] OP_ROT_RIGHT = 7'h19;
  localparam logic [6:0] OP_SUB = 7'h05;
  localparam logic [6:0] OP_SWAP = 7'h1D;
  // literal forms, top four bits
  localparam logic [3:0] OP_AND_LIT = 4'hE;
  localparam logic [3:0] OP_OR_LIT = 4'hD;
  localparam logic [3:0] OP_XOR_LIT = 4'hF;
  // whole-word forms
  localparam logic [11:0] OP_CLR_W = 12'h040;
  localparam logic [11:0] OP_CLR_WDOG = 12'h004;
endpackage

// ---- logic_arith_instr_exec.sv ----
`timescale 1ns/10ps
// Function
// - instruction rate is clock divided one or four
// - plain instructions take one instruction cycle
// - skip instructions take one or two cycles
// - and into file, accumulator or literal
// - not inverts file operand, updates null flag
// - inclusive or forms, null flag only
// - exclusive or forms, null flag only
// - add with optional carry, three flags
// - sub file minus accumulator, three flags
// - watchdog clear resets counter, sets two flags
// - dec file operand, null flag only
// - inc file operand, null flag only
// - dec, skip on zero, flags untouched
// - inc, skip on zero, flags untouched
// - rotate left through outflow bit
// - rotate right through outflow bit
// - swap nibbles, flags untouched
// - null flag is status bit two
// - outflow bit is status bit zero
// - nibble outflow is status bit one
// - expiry bit four, sleep bit three
module logic_arith_instr_exec
  import logic_arith_pkg::*;
#(
  parameter int FILE_DEPTH = 32
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import logic_arith_pkg::*;

  logic [7:0] file_mem [FILE_DEPTH];
  logic [2:0] ctrl_reg, ctrl_next;
  logic [11:0] instr_reg, instr_next;
  logic [7:0] acc_reg, acc_next;
  logic [7:0] status_reg, status_next;
  logic [7:0] wdt_reg, wdt_next;
  logic [7:0] presc_reg, presc_next;
  logic [31:0] cycle_reg, cycle_next;
  logic [1:0] div_reg, div_next;
  logic skip_reg, skip_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic mem_we;
  logic [4:0] mem_addr;
  logic [7:0] mem_wdata;

  // alu outputs
  logic [7:0] res, fval, opnd;
  logic wr_file, wr_acc, upd_null, upd_out, upd_nib, out_val, nib_val;
  logic skip_set, wdog_clear;
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic cin;

  logic access, fire, is_instr_wr, hit, tick, wdt_ovf;
  logic [4:0] file_idx;

  function automatic logic file_hit(input logic [11:0] a);
    file_hit = (a >= FILE_BASE) && (a < FILE_BASE + 12'(4 * FILE_DEPTH))
      && (a[1:0] == 2'h0);
  endfunction

  assign access = psel && penable;
  assign is_instr_wr = pwrite && (paddr == INSTR_OFF);
  assign fire = access && pready_reg && is_instr_wr;
  assign file_idx = 5'((paddr - FILE_BASE) >> 2);
  assign hit = file_hit(paddr) || paddr == CTRL_OFF || paddr == INSTR_OFF
    || paddr == ACC_OFF || paddr == STATUS_OFF || paddr == WDT_OFF
    || paddr == CYCLE_OFF;
  assign tick = (div_reg == 2'h0);

  assign fval = file_mem[pwdata[4:0]];

  always_comb begin
    res = 8'h00;
    wr_file = 1'b0;
    wr_acc = 1'b0;
    upd_null = 1'b0;
    upd_out = 1'b0;
    upd_nib = 1'b0;
    out_val = 1'b0;
    nib_val = 1'b0;
    skip_set = 1'b0;
    wdog_clear = 1'b0;
    opnd = pwdata[7:0];
    // carry joins in only with the fuse clear
    cin = ~ctrl_reg[CTRL_CARRY_FUSE_BIT] & status_reg[ST_OUTFLOW_BIT];
    sum9 = {1'b0, fval} + {1'b0, acc_reg} + {8'h00, cin};
    sum5 = {1'b0, fval[3:0]} + {1'b0, acc_reg[3:0]} + {4'h0, cin};
    case (pwdata[11:8])
      OP_AND_LIT: begin
        res = acc_reg & opnd;
        wr_acc = 1'b1;
        upd_null = 1'b1;
      end
      OP_OR_LIT: begin
        res = acc_reg | opnd;
        wr_acc = 1'b1;
        upd_null = 1'b1;
      end
      OP_XOR_LIT: begin
        res = acc_reg ^ opnd;
        wr_acc = 1'b1;
        upd_null = 1'b1;
      end
      default: begin
        upd_null = 1'b1;
        case (pwdata[11:5])
          OP_AND_FW, OP_AND_WF: res = acc_reg & fval;
          OP_NOT: res = fval ^ 8'hFF;
          OP_OR_FW, OP_OR_WF: res = acc_reg | fval;
          OP_XOR_FW, OP_XOR_WF: res = acc_reg ^ fval;
          OP_ADD_FW, OP_ADD_WF: begin
            res = sum9[7:0];
            {upd_out, out_val} = {1'b1, sum9[8]};
            {upd_nib, nib_val} = {1'b1, sum5[4]};
          end
          OP_SUB: begin
            cin = ctrl_reg[CTRL_CARRY_FUSE_BIT] | status_reg[ST_OUTFLOW_BIT];
            sum9 = {1'b0, fval} + {1'b0, ~acc_reg} + {8'h00, cin};
            sum5 = {1'b0, fval[3:0]} + {1'b0, ~acc_reg[3:0]} + {4'h0, cin};
            res = sum9[7:0];
            {upd_out, out_val} = {1'b1, sum9[8]};
            {upd_nib, nib_val} = {1'b1, sum5[4]};
          end
          OP_CLR_F: res = 8'h00;
          OP_DEC: res = fval - 8'h01;
          OP_INC: res = fval + 8'h01;
          OP_DECSKIP: begin
            res = fval - 8'h01;
            upd_null = 1'b0;
            skip_set = (res == 8'h00);
          end
          OP_INCSKIP: begin
            res = fval + 8'h01;
            upd_null = 1'b0;
            skip_set = (res == 8'h00);
          end
          OP_ROT_LEFT: begin
            res = {fval[6:0], status_reg[ST_OUTFLOW_BIT]};
            {upd_null, upd_out, out_val} = {2'h1, fval[7]};
          end
          OP_ROT_RIGHT: begin
            res = {status_reg[ST_OUTFLOW_BIT], fval[7:1]};
            {upd_null, upd_out, out_val} = {2'h1, fval[0]};
          end
          OP_SWAP: begin
            res = {fval[3:0], fval[7:4]};
            upd_null = 1'b0;
          end
          default: upd_null = 1'b0;
        endcase
        // bit 5 of these opcodes selects the file destination
        wr_file = upd_null && pwdata[5];
        wr_acc = upd_null && !pwdata[5];
        if (pwdata[11:5] inside {OP_DECSKIP, OP_INCSKIP, OP_SWAP,
            OP_ROT_LEFT, OP_ROT_RIGHT, OP_NOT, OP_INC, OP_DEC}) begin
          wr_file = 1'b1;
          wr_acc = 1'b0;
        end
        if (pwdata[11:0] == OP_CLR_W) begin
          {res, wr_acc, upd_null} = {8'h00, 2'h3};
        end
        if (pwdata[11:0] == OP_CLR_WDOG) begin
          wdog_clear = 1'b1;
        end
      end
    endcase
  end

  always_comb begin
    ctrl_next = ctrl_reg;
    instr_next = instr_reg;
    acc_next = acc_reg;
    status_next = status_reg;
    skip_next = skip_reg;
    cycle_next = cycle_reg;
    mem_we = 1'b0;
    mem_addr = file_idx;
    mem_wdata = pwdata[7:0];
    // one or four clocks per instruction cycle
    if (ctrl_reg[CTRL_QUARTER_BIT] && div_reg != DIV_QUARTER_LAST) begin
      div_next = div_reg + 2'h1;
    end else begin
      div_next = DIV_TURBO_LAST;
    end
    // a pending instruction holds the bus until its cycle starts
    pready_next = access && !pready_reg && (!is_instr_wr || div_next == 2'h0);
    pslverr_next = pready_next && !hit;
    prdata_next = 32'h0000_0000;
    if (pready_next && !pwrite) begin
      if (file_hit(paddr)) prdata_next = {24'h0, file_mem[file_idx]};
      else if (paddr == CTRL_OFF) prdata_next = {29'h0, ctrl_reg};
      else if (paddr == INSTR_OFF) prdata_next = {20'h0, instr_reg};
      else if (paddr == ACC_OFF) prdata_next = {24'h0, acc_reg};
      else if (paddr == STATUS_OFF) prdata_next = {24'h0, status_reg};
      else if (paddr == WDT_OFF) prdata_next = {24'h0, wdt_reg};
      else if (paddr == CYCLE_OFF) prdata_next = cycle_reg;
    end
    if (access && pready_reg && pwrite) begin
      if (file_hit(paddr)) mem_we = 1'b1;
      if (paddr == CTRL_OFF) ctrl_next = pwdata[2:0];
      if (paddr == ACC_OFF) acc_next = pwdata[7:0];
      if (paddr == STATUS_OFF) status_next = pwdata[7:0];
    end
    if (fire) begin
      instr_next = pwdata[11:0];
      cycle_next = cycle_reg + 32'h1;
      if (skip_reg) begin
        // skipped word only burns its cycle
        skip_next = 1'b0;
      end else begin
        // a taken skip adds the next word's cycle
        skip_next = skip_set;
        mem_we = wr_file;
        mem_addr = pwdata[4:0];
        mem_wdata = res;
        if (wr_acc) acc_next = res;
        if (upd_null) status_next[ST_NULL_BIT] = (res == 8'h00);
        if (upd_out) status_next[ST_OUTFLOW_BIT] = out_val;
        if (upd_nib) status_next[ST_NIBBLE_BIT] = nib_val;
        if (wdog_clear) begin
          status_next[ST_EXPIRY_BIT] = 1'b1;
          status_next[ST_SLEEP_BIT] = 1'b1;
        end
      end
    end
    // timeout clears expiry; it wins over a software write
    if (wdt_ovf) status_next[ST_EXPIRY_BIT] = 1'b0;
  end

  // watchdog counts instruction cycles, optionally through the prescaler
  always_comb begin
    presc_next = presc_reg;
    wdt_next = wdt_reg;
    wdt_ovf = 1'b0;
    if (tick) begin
      if (ctrl_reg[CTRL_PRESC_WDT_BIT]) presc_next = presc_reg + 8'h01;
      if (!ctrl_reg[CTRL_PRESC_WDT_BIT] || presc_reg == 8'hFF) begin
        wdt_next = wdt_reg + 8'h01;
        wdt_ovf = (wdt_reg == 8'hFF);
      end
    end
    if (fire && !skip_reg && wdog_clear) begin
      wdt_next = 8'h00;
      wdt_ovf = 1'b0;
      if (ctrl_reg[CTRL_PRESC_WDT_BIT]) presc_next = 8'h00;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= CTRL_RESET;
      instr_reg <= 12'h000;
      acc_reg <= 8'h00;
      status_reg <= STATUS_RESET;
      wdt_reg <= 8'h00;
      presc_reg <= 8'h00;
      cycle_reg <= 32'h0000_0000;
      div_reg <= 2'h0;
      skip_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      for (int i = 0; i < FILE_DEPTH; i++) file_mem[i] <= 8'h00;
    end else begin
      ctrl_reg <= ctrl_next;
      instr_reg <= instr_next;
      acc_reg <= acc_next;
      status_reg <= status_next;
      wdt_reg <= wdt_next;
      presc_reg <= presc_next;
      cycle_reg <= cycle_next;
      div_reg <= div_next;
      skip_reg <= skip_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      if (mem_we) file_mem[mem_addr] <= mem_wdata;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_exec_on_tick: assert property (fire |-> tick)
    else $error("instruction executed off an instruction cycle");
  chk_quarter_seq: assert property (
    (tick && ctrl_reg[CTRL_QUARTER_BIT])[*4] |-> 1'b0)
    else $error("quarter rate stayed on cycle start");
  chk_cycle_count: assert property (
    fire |=> cycle_reg == $past(cycle_reg) + 32'h1)
    else $error("cycle counter did not advance");
  chk_skip_arm: assert property (
    fire && !skip_reg && skip_set |=> skip_reg)
    else $error("zero result did not arm skip");
  chk_skip_nop: assert property (
    fire && skip_reg |=> $stable(acc_reg) && !skip_reg
      && status_reg[3:0] == $past(status_reg[3:0]))
    else $error("skipped instruction changed state");
  chk_null_flag: assert property (
    fire && !skip_reg && upd_null |=> status_reg[ST_NULL_BIT]
      == ($past(res) == 8'h00))
    else $error("null flag does not match result");
  chk_wdog_flags: assert property (
    fire && !skip_reg && wdog_clear |=> wdt_reg == 8'h00
      && status_reg[ST_SLEEP_BIT])
    else $error("watchdog clear incomplete");
  chk_swap_flags: assert property (
    fire && !skip_reg && pwdata[11:5] == OP_SWAP
      |=> status_reg[2:0] == $past(status_reg[2:0]))
    else $error("swap changed a flag");
  chk_unmapped_err: assert property (
    pready_reg && !$past(pready_reg) && pslverr_reg |-> prdata_reg == 32'h0)
    else $error("error answer carried data");

  cov_skip_taken: cover property (fire && skip_reg);
  cov_wdog_clear: cover property (fire && wdog_clear);
  cov_quarter_exec: cover property (fire && ctrl_reg[CTRL_QUARTER_BIT]);
  cov_add_carry: cover property (fire && upd_nib && out_val);
endmodule

// ---- prog_store.sv ----
`timescale 1ns/10ps
module prog_store (
  // fetch port
  input wire logic [4:0] pc,
  output logic [11:0] word
);
  import logic_arith_pkg::*;
  // words past the table read as zero, which the core treats as a no-op
  always_comb begin
    case (pc)
      5'h00: word = {OP_AND_WF, 5'h01};
      5'h01: word = {OP_OR_FW, 5'h01};
      5'h02: word = {OP_ADD_WF, 5'h02};
      5'h03: word = {OP_SUB, 5'h03};
      5'h04: word = {OP_DECSKIP, 5'h04};
      5'h05: word = {OP_INC, 5'h04};
      5'h06: word = {OP_INC, 5'h04};
      5'h07: word = {OP_ROT_LEFT, 5'h05};
      5'h08: word = {OP_ROT_RIGHT, 5'h05};
      5'h09: word = {OP_SWAP, 5'h06};
      5'h0A: word = OP_CLR_WDOG;
      5'h0B: word = OP_CLR_W;
      5'h0C: word = {OP_XOR_LIT, 8'hAA};
      5'h0D: word = {OP_INCSKIP, 5'h08};
      5'h0E: word = {OP_DEC, 5'h08};
      5'h0F: word = {OP_DEC, 5'h08};
      5'h10: word = {OP_NOT, 5'h06};
      5'h11: word = {OP_INC, 5'h07};
      default: word = 12'h000;
    endcase
  end
endmodule

// ---- tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
  import logic_arith_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [4:0] pc = 5'h00;
  logic [11:0] word;
  logic [31:0] q;
  logic e;
  logic [7:0] c0;
  int n_mismatch = 0;
  int checked = 0;

  always #2 ref_clk = ~ref_clk;

  logic_arith_instr_exec dut_u (
    .ref_clk(ref_clk),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr)
  );

  prog_store mem_u (
    .pc(pc),
    .word(word)
  );

  task automatic summarize;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one full apb transfer; starts on a fresh edge so release and setup
  // never land in the same time step
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_mismatch++;
      $display("BAD pready expected 1 seen 0");
      summarize();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask

  task automatic rdc(input string name, input logic [11:0] a,
                     input logic [7:0] exp);
    apb(1'b0, a, 32'h0);
    check(name, {24'h0, q[7:0]}, {24'h0, exp});
  endtask

  function automatic logic [11:0] fa(input int i);
    return FILE_BASE + 12'(i * 4);
  endfunction

  // let the program store settle on the new index before the word is taken
  task automatic run(input logic [4:0] idx);
    pc <= idx;
    @(posedge ref_clk);
    apb(1'b1, INSTR_OFF, {20'h0, word});
  endtask

  task automatic s_reset;
    rdc("ctrl", CTRL_OFF, 8'h02);
    rdc("status", STATUS_OFF, 8'h18);
    rdc("acc", ACC_OFF, 8'h00);
  endtask

  task automatic s_logic;
    wr(ACC_OFF, 8'h0F);
    wr(fa(1), 8'hF0);
    run(5'h00);
    rdc("and acc", ACC_OFF, 8'h00);
    rdc("and status", STATUS_OFF, 8'h1C);
    run(5'h01);
    rdc("or file", fa(1), 8'hF0);
    rdc("or status", STATUS_OFF, 8'h18);
    run(5'h0C);
    rdc("xor lit", ACC_OFF, 8'hAA);
  endtask

  task automatic s_arith;
    wr(CTRL_OFF, 8'h00);
    wr(STATUS_OFF, 8'h01);
    wr(ACC_OFF, 8'h08);
    wr(fa(2), 8'h08);
    run(5'h02);
    rdc("add acc", ACC_OFF, 8'h11);
    rdc("add status", STATUS_OFF, 8'h02);
    // carry unused now, so only fr minus acc
    wr(CTRL_OFF, 8'h02);
    wr(ACC_OFF, 8'h06);
    wr(fa(3), 8'h05);
    run(5'h03);
    rdc("sub file", fa(3), 8'hFF);
    rdc("sub status", STATUS_OFF, 8'h00);
  endtask

  task automatic s_skip;
    wr(fa(4), 8'h01);
    apb(1'b0, CYCLE_OFF, 32'h0);
    c0 = q[7:0];
    run(5'h04);
    rdc("decskip status", STATUS_OFF, 8'h00);
    run(5'h05);
    run(5'h06);
    rdc("decskip file", fa(4), 8'h01);
    apb(1'b0, CYCLE_OFF, 32'h0);
    check("skip cycles", {24'h0, q[7:0] - c0}, 32'h3);
    wr(fa(8), 8'hFF);
    // null set first so an unskipped dec, which would clear it, shows
    wr(STATUS_OFF, 8'h04);
    run(5'h0D);
    run(5'h0E);
    rdc("incskip status", STATUS_OFF, 8'h04);
    run(5'h0F);
    rdc("dec file", fa(8), 8'hFF);
  endtask

  task automatic s_shift;
    wr(STATUS_OFF, 8'h00);
    wr(fa(5), 8'h81);
    run(5'h07);
    rdc("rl file", fa(5), 8'h02);
    rdc("rl status", STATUS_OFF, 8'h01);
    run(5'h08);
    rdc("rr file", fa(5), 8'h81);
    rdc("rr status", STATUS_OFF, 8'h00);
    wr(STATUS_OFF, 8'h04);
    wr(fa(6), 8'h3C);
    run(5'h09);
    rdc("swap file", fa(6), 8'hC3);
    rdc("swap status", STATUS_OFF, 8'h04);
    run(5'h10);
    rdc("not file", fa(6), 8'h3C);
    rdc("not status", STATUS_OFF, 8'h00);
  endtask

  task automatic s_clear;
    // prescaler on the watchdog keeps the counter frozen after the clear
    wr(CTRL_OFF, 8'h06);
    wr(ACC_OFF, 8'h55);
    run(5'h0A);
    rdc("wdog status", STATUS_OFF, 8'h18);
    rdc("wdog count", WDT_OFF, 8'h00);
    run(5'h0B);
    rdc("clr acc", ACC_OFF, 8'h00);
    rdc("clr status", STATUS_OFF, 8'h1C);
  endtask

  task automatic s_quarter;
    wr(CTRL_OFF, 8'h03);
    wr(fa(7), 8'h7F);
    apb(1'b0, CYCLE_OFF, 32'h0);
    c0 = q[7:0];
    run(5'h11);
    rdc("inc file", fa(7), 8'h80);
    rdc("inc status", STATUS_OFF, 8'h18);
    apb(1'b0, CYCLE_OFF, 32'h0);
    check("quarter cycles", {24'h0, q[7:0] - c0}, 32'h1);
    rdc("file index", fa(23), 8'h00);
  endtask

  task automatic s_unmapped;
    apb(1'b0, 12'h07C, 32'h0);
    check("unmapped err", {31'h0, e}, 32'h1);
    check("unmapped data", q, 32'h0);
  endtask

  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    s_reset();
    s_logic();
    s_arith();
    s_skip();
    s_shift();
    s_clear();
    s_quarter();
    s_unmapped();
    summarize();
  end
endmodule
